// [hw/sensor_reg_bank.sv]
// Serial-slave register bank of the inductive sensor converter
`timescale 1ns/1ps
// Overview of operation
// R1: While active power bit is set, addresses 0x01 to 0x05 ignore host writes.
// R2: Range maximum codes 0x00-0x1F pick fixed ohm limits, decreasing with code.
// R3: Host must always program range minimum; its reset code 0x14 is unusable.
// R4: Host writes documented defaults into unused and reserved fields.
// R5: Address 0x00 reads a fixed eight-bit silicon revision code.
// R6: Status carries oscillator, data-ready-low, wake and comparator flags on top.
// R7: Read-only registers reject writes; read/write registers take them.
// R8: Reset leaves stand-by with conversion off until host sets power bit.
// R9: 24-bit frequency count reads at 0x23-0x25, low byte first, after proximity.
// R10: Pin mode 000 off, 001 wake, 010 comparator, 100 data-ready, rest reserved.
// R11: Rejected writes change nothing, give no error, and reads still see contents.
module sensor_reg_bank #(
   parameter logic [7:0] REVISION_ID = 8'h5A // Arbitrary value
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic spi_sclk,
   input wire logic spi_csb,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   input sensor_regs_pkg::conv_result_s conv,
   output sensor_regs_pkg::config_s cfg,
   output logic [21:0] range_max_ohm,
   output logic [21:0] range_min_ohm,
   output logic range_min_usable,
   output logic interrupt_pin_n
);
   import sensor_regs_pkg::*;

   typedef struct packed {
      phase_e ph;
      logic [2:0] bit_cnt;
      logic is_read;
      logic [6:0] addr;
      logic [7:0] rx;
      logic [7:0] tx;
      logic sclk_d;
      logic sdo;
      logic sdo_oe_n;
      logic [7:0] range_max;
      logic [7:0] range_min;
      logic [7:0] wdog;
      logic [7:0] conv_cfg;
      logic [7:0] rsvd_b;
      logic [7:0] thr_hi;
      logic [7:0] rsvd_c;
      logic [7:0] thr_lo;
      logic [7:0] int_cfg;
      logic [7:0] pwr;
      config_s cfg;
      logic [21:0] ohm_max;
      logic [21:0] ohm_min;
      logic min_ok;
      logic int_n;
   } state_s;

   state_s q;
   state_s n;
   logic sclk_l;
   logic csb_l;
   logic sdi_l;
   logic [21:0] ohm_max_c;
   logic [21:0] ohm_min_c;
   logic min_ok_c;
   logic rise;
   logic fall;
   logic byte_done;
   logic wr_ev;
   logic ld_ev;
   logic [6:0] ld_addr;
   logic [7:0] rx_full;
   logic locked;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and range tables
   pin_sync #(
      .W(3),
      .RST_LVL(3'b010)
   ) u_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pin_in({spi_sclk, spi_csb, spi_sdi}),
      .level_out({sclk_l, csb_l, sdi_l})
   );

   range_lookup #(
      .CODE_BASE(MAX_CODE_BASE)
   ) u_max (
      .code(q.range_max),
      .ohm(ohm_max_c),
      .usable()
   );

   range_lookup #(
      .CODE_BASE(MIN_CODE_BASE)
   ) u_min (
      .code(q.range_min),
      .ohm(ohm_min_c),
      .usable(min_ok_c)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped and pad addresses read zero
   function automatic logic [7:0] read_reg(input logic [6:0] a);
      logic [7:0] d;
      d = READ_ZERO;
      unique case (a)
         ADDR_REVISION: d = REVISION_ID; // R5
         ADDR_RANGE_MAX: d = q.range_max;
         ADDR_RANGE_MIN: d = q.range_min;
         ADDR_WDOG: d = q.wdog;
         ADDR_CONV_CFG: d = q.conv_cfg;
         ADDR_RSVD_A: d = RST_RSVD_A;
         ADDR_RSVD_B: d = q.rsvd_b;
         ADDR_THR_HI: d = q.thr_hi;
         ADDR_RSVD_C: d = q.rsvd_c;
         ADDR_THR_LO: d = q.thr_lo;
         ADDR_INT_CFG: d = q.int_cfg;
         ADDR_PWR_CFG: d = q.pwr;
         ADDR_STATUS: d = {conv.oscillator_flag, conv.data_ready_low_flag, conv.wake_flag,
                           conv.comp_flag, STATUS_LOW_BITS}; // R6
         ADDR_PROX: d = conv.prox;
         ADDR_FC_LO: d = conv.fcount[7:0]; // R9
         ADDR_FC_MID: d = conv.fcount[15:8]; // R9
         ADDR_FC_HI: d = conv.fcount[23:16]; // R9
         default: d = READ_ZERO;
      endcase
      return d;
   endfunction : read_reg

   // Pin mode decode
   function automatic int_mode_e decode_mode(input logic [2:0] m);
      int_mode_e r;
      r = MODE_RSVD;
      unique case (m)
         3'b000: r = MODE_OFF; // R10
         3'b001: r = MODE_WAKE; // R10
         3'b010: r = MODE_COMP; // R10
         3'b100: r = MODE_DRDY; // R10
         default: r = MODE_RSVD; // R10
      endcase
      return r;
   endfunction : decode_mode

   ////////////////////////////////////////////////////////////////////////////////
   // Serial events; bytes complete on the eighth rising clock edge
   assign rise = sclk_l & ~q.sclk_d;
   assign fall = ~sclk_l & q.sclk_d;
   assign byte_done = ~csb_l & rise & (q.bit_cnt == BIT_LAST);
   assign rx_full = {q.rx[6:0], sdi_l};
   assign wr_ev = byte_done & (q.ph == PH_DATA) & ~q.is_read;
   assign ld_ev = byte_done;
   assign ld_addr = (q.ph == PH_CMD) ? rx_full[6:0] : q.addr + 7'h01;
   assign locked = q.pwr[PWR_ACTIVE_BIT] && (q.addr >= LOCK_FIRST) && (q.addr <= LOCK_LAST);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state: framing, register writes, outputs
   always_comb
   begin
      n = q;
      n.sclk_d = sclk_l;
      if (csb_l)
      begin
         // Deselect abandons any partial byte, so a short frame writes nothing
         n.ph = PH_CMD;
         n.bit_cnt = 3'h0;
         n.sdo = 1'b0;
         n.sdo_oe_n = 1'b1;
      end
      else
      begin
         n.sdo_oe_n = 1'b0;
         if (rise)
         begin
            n.rx = rx_full;
            n.bit_cnt = q.bit_cnt + 3'h1;
         end
         if (byte_done)
         begin
            unique case (q.ph)
               PH_CMD:
               begin
                  n.is_read = rx_full[CMD_READ_BIT];
                  n.ph = PH_DATA;
               end
               PH_DATA:
               begin
                  if (!q.is_read && !locked) // R1
                  begin
                     // Read-only addresses fall through untouched, no error
                     unique case (q.addr) // R7 R11
                        ADDR_RANGE_MAX: n.range_max = rx_full;
                        ADDR_RANGE_MIN: n.range_min = rx_full;
                        ADDR_WDOG: n.wdog = rx_full;
                        ADDR_CONV_CFG: n.conv_cfg = rx_full & MASK_CONV_CFG;
                        ADDR_RSVD_B: n.rsvd_b = rx_full;
                        ADDR_THR_HI: n.thr_hi = rx_full;
                        ADDR_RSVD_C: n.rsvd_c = rx_full;
                        ADDR_THR_LO: n.thr_lo = rx_full;
                        ADDR_INT_CFG: n.int_cfg = rx_full & MASK_INT_CFG;
                        ADDR_PWR_CFG: n.pwr = rx_full & MASK_PWR_CFG; // R8
                        default: n.rx = rx_full;
                     endcase
                  end
               end
            endcase
            // Auto-increment for extended frames; data is fetched one byte ahead
            n.addr = ld_addr;
            n.tx = read_reg(ld_addr);
         end
         if (fall && (q.ph == PH_DATA) && q.is_read)
         begin
            n.sdo = q.tx[7];
            n.tx = {q.tx[6:0], 1'b0};
         end
      end
      // Settings to the engine, one cycle behind the register file
      n.cfg.impedance_range_max = q.range_max;
      n.cfg.impedance_range_min = q.range_min;
      n.cfg.wdog_min_freq = q.wdog;
      n.cfg.amplitude = q.conv_cfg[CONV_AMP_LSB +: 2];
      n.cfg.response_time = q.conv_cfg[CONV_RESP_LSB +: 3];
      n.cfg.thr_high = q.thr_hi;
      n.cfg.thr_low = q.thr_lo;
      n.cfg.interrupt_pin_mode = decode_mode(q.int_cfg[2:0]); // R10
      n.cfg.active_power_bit = q.pwr[PWR_ACTIVE_BIT]; // R8
      n.ohm_max = ohm_max_c; // R2
      n.ohm_min = ohm_min_c;
      n.min_ok = min_ok_c; // R3
      // Active-low pin follows the flag that the mode selects
      unique case (q.cfg.interrupt_pin_mode)
         MODE_WAKE: n.int_n = ~conv.wake_flag;
         MODE_COMP: n.int_n = ~conv.comp_flag;
         MODE_DRDY: n.int_n = conv.data_ready_low_flag;
         default: n.int_n = 1'b1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; reset comes up in stand-by with documented defaults
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         q <= '0;
         q.sdo_oe_n <= 1'b1;
         q.range_max <= RST_RANGE_MAX;
         q.range_min <= RST_RANGE_MIN;
         q.wdog <= RST_WDOG;
         q.conv_cfg <= RST_CONV_CFG;
         q.rsvd_b <= RST_RSVD_B;
         q.thr_hi <= RST_THR_HI;
         q.rsvd_c <= RST_RSVD_C;
         q.thr_lo <= RST_THR_LO;
         q.int_cfg <= RST_INT_CFG;
         q.pwr <= RST_PWR_CFG; // R8
         q.int_n <= 1'b1;
      end
      else
      begin
         q <= n;
      end
   end

   assign spi_sdo = q.sdo;
   assign spi_sdo_oe_n = q.sdo_oe_n;
   assign cfg = q.cfg;
   assign range_max_ohm = q.ohm_max;
   assign range_min_ohm = q.ohm_min;
   assign range_min_usable = q.min_ok;
   assign interrupt_pin_n = q.int_n;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [4:0] rmax_idx;
   logic [7:0] status_now;
   logic [7:0] fc_lo;
   logic [7:0] fc_hi;
   logic drdy_n_now;
   logic [79:0] rw_bank;
   assign rmax_idx = q.range_max[4:0];
   assign status_now = {conv.oscillator_flag, conv.data_ready_low_flag, conv.wake_flag,
                        conv.comp_flag, STATUS_LOW_BITS};
   assign fc_lo = conv.fcount[7:0];
   assign fc_hi = conv.fcount[23:16];
   assign drdy_n_now = conv.data_ready_low_flag;
   assign rw_bank = {q.range_max, q.range_min, q.wdog, q.conv_cfg, q.rsvd_b, q.thr_hi,
                     q.rsvd_c, q.thr_lo, q.int_cfg, q.pwr};

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   lock_window_a: assert property (q.pwr[PWR_ACTIVE_BIT] && $past(q.pwr[PWR_ACTIVE_BIT]) // R1
      |-> $stable(q.range_max) && $stable(q.range_min) && $stable(q.wdog)
          && $stable(q.conv_cfg))
      else $error("locked range register changed while active");
   range_map_a: assert property ((q.range_max <= RANGE_CODE_SPAN) // R2
      |=> q.ohm_max == RP_OHM[$past(rmax_idx)])
      else $error("range maximum ohms do not match code");
   revision_read_a: assert property ($rose(q.ph == PH_DATA) && q.is_read // R5
      && (q.addr == ADDR_REVISION) |-> q.tx == REVISION_ID)
      else $error("revision byte wrong");
   status_layout_a: assert property ($rose(q.ph == PH_DATA) && q.is_read // R6
      && (q.addr == ADDR_STATUS) |-> q.tx == $past(status_now))
      else $error("status byte layout wrong");
   ro_write_a: assert property (wr_ev && ((q.addr == ADDR_REVISION) // R7 R11
      || (q.addr == ADDR_RSVD_A) || (q.addr >= ADDR_STATUS)) |=> $stable(rw_bank))
      else $error("write to read-only address changed the bank");
   standby_reset_a: assert property ($past(sys_rst) // R8
      |-> !q.pwr[PWR_ACTIVE_BIT] ##1 !q.cfg.active_power_bit)
      else $error("not in stand-by after reset");
   fcount_low_a: assert property (ld_ev && (ld_addr == ADDR_FC_LO) // R9
      |=> q.tx == $past(fc_lo))
      else $error("frequency count low byte wrong");
   fcount_high_a: assert property (ld_ev && (ld_addr == ADDR_FC_HI) // R9
      |=> q.tx == $past(fc_hi))
      else $error("frequency count high byte wrong");
   mode_drdy_a: assert property ((q.int_cfg[2:0] == 3'b100) // R10
      |=> (q.cfg.interrupt_pin_mode == MODE_DRDY)
          ##1 (q.cfg.interrupt_pin_mode != MODE_DRDY || interrupt_pin_n == $past(drdy_n_now)))
      else $error("data-ready pin mode wrong");
   // Any code outside the four defined ones must decode as reserved
   mode_rsvd_a: assert property (!(q.int_cfg[2:0] inside {3'b000, 3'b001, 3'b010, 3'b100}) // R10
      |=> q.cfg.interrupt_pin_mode == MODE_RSVD)
      else $error("reserved pin mode not flagged");

   burst_read_c: cover property (ld_ev && (ld_addr == ADDR_FC_HI) && q.is_read);
   locked_write_c: cover property (wr_ev && locked);
   drdy_mode_c: cover property (q.cfg.interrupt_pin_mode == MODE_DRDY && !interrupt_pin_n);

endmodule : sensor_reg_bank

// [include/sensor_regs_pkg.sv]
// Package: register map, field layout, reset values and shared types of the sensor bank
package sensor_regs_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register addresses (7-bit serial address space)
   localparam logic [6:0] ADDR_REVISION = 7'h00;
   localparam logic [6:0] ADDR_RANGE_MAX = 7'h01;
   localparam logic [6:0] ADDR_RANGE_MIN = 7'h02;
   localparam logic [6:0] ADDR_WDOG = 7'h03;
   localparam logic [6:0] ADDR_CONV_CFG = 7'h04;
   localparam logic [6:0] ADDR_RSVD_A = 7'h05;
   localparam logic [6:0] ADDR_RSVD_B = 7'h06;
   localparam logic [6:0] ADDR_THR_HI = 7'h07;
   localparam logic [6:0] ADDR_RSVD_C = 7'h08;
   localparam logic [6:0] ADDR_THR_LO = 7'h09;
   localparam logic [6:0] ADDR_INT_CFG = 7'h0A;
   localparam logic [6:0] ADDR_PWR_CFG = 7'h0B;
   localparam logic [6:0] ADDR_STATUS = 7'h20;
   localparam logic [6:0] ADDR_STATUS_PAD = 7'h21;
   localparam logic [6:0] ADDR_PROX = 7'h22;
   localparam logic [6:0] ADDR_FC_LO = 7'h23;
   localparam logic [6:0] ADDR_FC_MID = 7'h24;
   localparam logic [6:0] ADDR_FC_HI = 7'h25;
   // Window frozen while converting
   localparam logic [6:0] LOCK_FIRST = 7'h01;
   localparam logic [6:0] LOCK_LAST = 7'h05;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values and writable-field masks
   localparam logic [7:0] RST_RANGE_MAX = 8'h0E;
   localparam logic [7:0] RST_RANGE_MIN = 8'h14;
   localparam logic [7:0] RST_WDOG = 8'h45;
   localparam logic [7:0] RST_CONV_CFG = 8'h1B;
   localparam logic [7:0] RST_RSVD_A = 8'h01;
   localparam logic [7:0] RST_RSVD_B = 8'hFF;
   localparam logic [7:0] RST_THR_HI = 8'hFF;
   localparam logic [7:0] RST_RSVD_C = 8'h00;
   localparam logic [7:0] RST_THR_LO = 8'h00;
   localparam logic [7:0] RST_INT_CFG = 8'h00;
   localparam logic [7:0] RST_PWR_CFG = 8'h00;
   localparam logic [7:0] MASK_CONV_CFG = 8'h1F;
   localparam logic [7:0] MASK_INT_CFG = 8'h07;
   localparam logic [7:0] MASK_PWR_CFG = 8'h01;
   localparam logic [7:0] READ_ZERO = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions and serial framing
   localparam int PWR_ACTIVE_BIT = 0;
   localparam int CONV_AMP_LSB = 3;
   localparam int CONV_RESP_LSB = 0;
   localparam int CMD_READ_BIT = 7;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [3:0] STATUS_LOW_BITS = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // Impedance range codes: maximum uses 0x00..0x1F, minimum uses 0x20..0x3F
   localparam logic [7:0] MAX_CODE_BASE = 8'h00;
   localparam logic [7:0] MIN_CODE_BASE = 8'h20;
   localparam logic [7:0] RANGE_CODE_SPAN = 8'h1F;
   // Impedance in ohms for each code step, decreasing
   localparam logic [21:0] RP_OHM [0:31] = '{
      22'h3BEBCF, 22'h2FEFD9, 22'h223D9B, 22'h1AA1B1, 22'h13F945, 22'h0EFAF4,
      22'h0B69DE, 22'h08E090, 22'h06A86C, 22'h05538A, 22'h03CDF5, 22'h02F586,
      22'h023824, 22'h01AA1B, 22'h0144A7, 22'h00FC82, 22'h00BD61, 22'h009781,
      22'h006C38, 22'h00542B, 22'h003F20, 22'h002F58, 22'h002413, 22'h001C0E,
      22'h00150B, 22'h0010D5, 22'h000C06, 22'h00095A, 22'h000704, 22'h000543,
      22'h000402, 22'h00031E};

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_WAKE = 3'b001,
      MODE_COMP = 3'b010,
      MODE_DRDY = 3'b100,
      MODE_RSVD = 3'b111
   } int_mode_e;

   typedef enum logic {
      PH_CMD = 1'b0,
      PH_DATA = 1'b1
   } phase_e;

   // Live results from the conversion engine
   typedef struct packed {
      logic oscillator_flag;
      logic data_ready_low_flag;
      logic wake_flag;
      logic comp_flag;
      logic [7:0] prox;
      logic [23:0] fcount;
   } conv_result_s;

   // Settings handed to the conversion engine
   typedef struct packed {
      logic [7:0] impedance_range_max;
      logic [7:0] impedance_range_min;
      logic [7:0] wdog_min_freq;
      logic [1:0] amplitude;
      logic [2:0] response_time;
      logic [7:0] thr_high;
      logic [7:0] thr_low;
      int_mode_e interrupt_pin_mode;
      logic active_power_bit;
   } config_s;

endpackage : sensor_regs_pkg

// [hw/pin_sync.sv]
// Three-stage synchroniser with agreement filter for the serial pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_LVL = '0
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } sync_s;

   sync_s q;
   sync_s n;

   ////////////////////////////////////////////////////////////////////////////////
   // Level moves only when stages two and three agree; stage one feeds only stage two
   always_comb
   begin
      n = q;
      n.s1 = pin_in;
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.lvl = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.lvl);
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         q.s1 <= RST_LVL;
         q.s2 <= RST_LVL;
         q.s3 <= RST_LVL;
         q.lvl <= RST_LVL;
      end
      else
      begin
         q <= n;
      end
   end

   assign level_out = q.lvl;

endmodule : pin_sync

// [hw/range_lookup.sv]
// Impedance range code to ohms translation
`timescale 1ns/1ps
module range_lookup
   import sensor_regs_pkg::*;
#(
   parameter logic [7:0] CODE_BASE = 8'h00
) (
   input wire logic [7:0] code,
   output logic [21:0] ohm,
   output logic usable
);
   logic [7:0] offs;

   ////////////////////////////////////////////////////////////////////////////////
   // Codes outside the table clamp to the nearest end and are flagged unusable
   always_comb
   begin
      offs = code - CODE_BASE;
      usable = (code >= CODE_BASE) && (offs <= RANGE_CODE_SPAN);
      if (code < CODE_BASE)
      begin
         ohm = RP_OHM[0];
      end
      else if (offs > RANGE_CODE_SPAN)
      begin
         ohm = RP_OHM[31];
      end
      else
      begin
         ohm = RP_OHM[offs[4:0]]; // R2
      end
   end

endmodule : range_lookup

// [bench/spi_host_model.sv]
// Host-side serial master model that drives the register bank pins
`timescale 1ns/1ps
module spi_host_model (
   input wire logic clk_sys,
   output logic spi_sclk,
   output logic spi_csb,
   output logic spi_sdi,
   input wire logic spi_sdo
);
   logic [7:0] data [0:15];

   ////////////////////////////////////////////////////////////////////////////////
   // Idle levels at time zero: clock low in mode 0, device deselected
   initial
   begin
      spi_sclk = 1'b0;
      spi_csb = 1'b1;
      spi_sdi = 1'b0;
   end

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wait_n

   // Six clocks per phase keeps each level above the pin filter delay
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         spi_sclk <= 1'b0;
         spi_sdi <= tx[i];
         wait_n(6);
         rx[i] = spi_sdo; // Settled well after the falling edge
         spi_sclk <= 1'b1;
         wait_n(6);
      end
   endtask : shift

   // One framed access: command byte, then n whole data bytes through data[]
   task automatic frame(input logic [7:0] cmd, input int n);
      logic [7:0] junk;
      spi_csb <= 1'b0;
      wait_n(6);
      shift(cmd, junk);
      for (int k = 0; k < n; k++)
         shift(data[k], data[k]);
      spi_sclk <= 1'b0;
      wait_n(6);
      spi_csb <= 1'b1;
      spi_sdi <= ~spi_sdi; // Released line must not keep showing the last bit
      wait_n(6);
   endtask : frame
endmodule : spi_host_model

// [bench/sensor_reg_bank_tb_top.sv]
// Self-checking testbench of the sensor register bank
`timescale 1ns/1ps
module sensor_reg_bank_tb_top;
   import sensor_regs_pkg::*;
   localparam logic [7:0] REV = 8'h3C; // Arbitrary value
   localparam logic [7:0] DEF [0:11] = '{REV, 8'h0E, 8'h14, 8'h45, 8'h1B, 8'h01, 8'hFF,
      8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] RES [0:5] = '{8'hB0, 8'h00, 8'h5C, 8'h56, 8'h34, 8'h12};
   localparam logic [6:0] RO_ADDR [0:7] = '{7'h00, 7'h05, 7'h20, 7'h21, 7'h22, 7'h23,
      7'h24, 7'h25};
   // Reserved 0x06 and 0x08 are written with their defaults only
   localparam logic [7:0] RW [0:3] = '{8'hFF, 8'h77, 8'h00, 8'h2D};
   localparam logic [7:0] NEWV [0:3] = '{8'h11, 8'h22, 8'h33, 8'h04};
   localparam logic [7:0] LOCKED [0:4] = '{8'h00, 8'h3B, 8'h45, 8'h1B, 8'h01};
   localparam logic [2:0] MODES [0:4] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b111};
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic spi_sclk, spi_csb, spi_sdi, spi_sdo, spi_sdo_oe_n, range_min_usable, interrupt_pin_n;
   logic [21:0] range_max_ohm, range_min_ohm;
   conv_result_s conv = {4'b1011, 8'h5C, 24'h123456};
   config_s cfg;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, device and host
   always #25 clk_sys = ~clk_sys;

   sensor_reg_bank #(.REVISION_ID(REV)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
      .spi_sdo_oe_n(spi_sdo_oe_n), .conv(conv), .cfg(cfg), .range_max_ohm(range_max_ohm),
      .range_min_ohm(range_min_ohm), .range_min_usable(range_min_usable),
      .interrupt_pin_n(interrupt_pin_n));

   // A released data line reads inverted, so a read outside the enable shows up
   spi_host_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo ^ spi_sdo_oe_n));

   ////////////////////////////////////////////////////////////////////////////////
   // Checking and access helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t ns: seen %0h, expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.data[0] = d;
      host.frame({1'b0, a}, 1);
   endtask : wr

   // Pin level expected per mode with wake = ~f, comparator = f, data-ready-low = f
   function automatic logic pin_exp(input logic [2:0] code, input logic f);
      case (code)
         3'b001: return f;
         3'b010: return ~f;
         3'b100: return f;
         default: return 1'b1;
      endcase
   endfunction : pin_exp

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // Cycle ceiling: a hang counts as a mismatch
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fail_count++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial
   begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(cfg.active_power_bit, 1'b0);
      chk(range_min_usable, 1'b0);
      chk(range_max_ohm, RP_OHM[14]);
      chk(spi_sdo_oe_n, 1'b1);
      chk({cfg.amplitude, cfg.response_time}, RST_CONV_CFG[4:0]);
      foreach (RO_ADDR[i]) wr(RO_ADDR[i], 8'hA5);
      wr(7'h10, 8'hA5);
      host.frame(8'h80, 12);
      for (int i = 0; i < 12; i++) chk(host.data[i], DEF[i]);
      host.frame(8'h90, 1);
      chk(host.data[0], 8'h00);
      host.frame(8'hA0, 6);
      for (int i = 0; i < 6; i++) chk(host.data[i], RES[i]);
      $display("test reset_readonly done");
      // Range codes at both ends and a programmed minimum
      wr(ADDR_RANGE_MIN, 8'h3B);
      chk(range_min_usable, 1'b1);
      chk(range_min_ohm, 22'd2394);
      wr(ADDR_RANGE_MAX, 8'h1F);
      chk(range_max_ohm, 22'd798);
      wr(ADDR_RANGE_MAX, 8'h00);
      chk(range_max_ohm, 22'd3926991);
      for (int i = 0; i < 4; i++) host.data[i] = RW[i];
      host.frame(8'h06, 4);
      host.frame(8'h86, 4);
      for (int i = 0; i < 4; i++) chk(host.data[i], RW[i]);
      chk(cfg.thr_high, 8'h77);
      chk(cfg.thr_low, 8'h2D);
      $display("test read_write done");
      // Each pin mode, with code 111 standing for reserved, against both flag patterns
      foreach (MODES[m])
      begin
         wr(ADDR_INT_CFG, {5'h00, MODES[m]});
         chk(cfg.interrupt_pin_mode, MODES[m]);
         for (int f = 0; f < 2; f++)
         begin
            conv.wake_flag <= ~f[0];
            conv.comp_flag <= f[0];
            conv.data_ready_low_flag <= f[0];
            repeat (4) @(posedge clk_sys);
            chk(interrupt_pin_n, pin_exp(MODES[m], f[0]));
         end
      end
      $display("test pin_modes done");
      // Writes in the locked window while active, then again in stand-by
      wr(ADDR_PWR_CFG, 8'h01);
      chk(cfg.active_power_bit, 1'b1);
      for (int i = 0; i < 4; i++) host.data[i] = NEWV[i];
      host.frame(8'h01, 4);
      host.frame(8'h81, 5);
      for (int i = 0; i < 5; i++) chk(host.data[i], LOCKED[i]);
      wr(ADDR_PWR_CFG, 8'h00);
      for (int i = 0; i < 4; i++) host.data[i] = NEWV[i];
      host.frame(8'h01, 4);
      host.frame(8'h81, 4);
      for (int i = 0; i < 4; i++) chk(host.data[i], NEWV[i]);
      chk(cfg.wdog_min_freq, 8'h33);
      chk(cfg.impedance_range_min, 8'h22);
      $display("test power_lock done");
      wrap_up();
   end
endmodule : sensor_reg_bank_tb_top
